// File: src/dcae_enum.sv
// dcae_enum: per-device identify interpreter for a daisy chain stack, with AXI4-Lite registers
// assumes whole command words arrive as one-cycle strobes from the link layer, which also
// tells whether every device nearer the master already holds a position
// Behaviour
// R1: answer own address and the broadcast address
// R2: role and rate pins readable in setup
// R3: setup register holds size, position, rate, role
// R4: words carried msb first, lsb last
// R5: reply to all but scan, measure, reset
// R6: host enumerates before other chain traffic
// R7: base identify starts enumeration mode
// R8: top acks then enters; others wait relay
// R9: entry loads position one for master, else zero
// R10: awaiting device takes N, replies role over N
// R11: identify response low data bits are zero
// R12: positioned devices track newest assigned address
// R13: top loads like others, replies 2x
// R14: host counts up from two until top
// R15: identify 3F ends mode; top acks
// R16: normal mode naks all but base identify
// R17: command checksum checked, bad frames dropped
// R18: checksum shift register, msb first
// R19: position kept until next base identify
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
module dcae_enum (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] role_select_bits,
	input wire logic [1:0] link_rate_bits,
	input wire logic prior_placed,
	input wire logic cmd_valid,
	input wire dcae_pkg::dcae_cmd_t cmd,
	output logic resp_valid,
	output dcae_pkg::dcae_kind_t resp_kind,
	output dcae_pkg::dcae_resp_t resp,
	output logic pass_valid,
	output dcae_pkg::dcae_cmd_t pass_cmd
);
	typedef enum logic [1:0] {ST_NORMAL, ST_RELAY, ST_ENUM} dcae_state_t;

	dcae_state_t st_q;
	logic [3:0] pos_q;
	logic [3:0] size_q;
	logic [15:0] relay_q;
	logic [15:0] relay_wait_q;
	logic resp_en_q;
	logic [7:0] crc_err_q;
	logic crc_ok;
	logic [3:0] resp_crc;
	dcae_pkg::dcae_resp_t body;
	dcae_pkg::dcae_kind_t kind;
	logic reply;

	// classification of the incoming word
	function automatic logic is_identify(input dcae_pkg::dcae_cmd_t c);
		is_identify = (c.page == dcae_pkg::ID_PAGE) && (c.daddr == dcae_pkg::ID_DADDR);
	endfunction : is_identify

	function automatic logic is_silent(input dcae_pkg::dcae_cmd_t c);
		is_silent = (c.page == dcae_pkg::SYS_PAGE) && ((c.daddr >= dcae_pkg::SCAN_DADDR_LO &&
			c.daddr <= dcae_pkg::SCAN_DADDR_HI) || c.daddr == dcae_pkg::MEASURE_DADDR ||
			c.daddr == dcae_pkg::RESET_DADDR);
	endfunction : is_silent

	logic good;
	logic ident;
	logic addressed;
	logic is_master;
	logic is_top;
	logic base_id;
	logic done_id;
	logic claim;
	logic track;
	logic enter;

	dcae_crc4 #(.W(24)) u_chk (
		.frame(cmd),
		.crc(),
		.match(crc_ok)
	);

	// command decode; a bad checksum makes the word invisible
	assign good = cmd_valid && crc_ok; // [R17]
	assign ident = is_identify(cmd);
	assign is_master = (role_select_bits == dcae_pkg::ROLE_MASTER);
	assign is_top = (role_select_bits == dcae_pkg::ROLE_TOP);
	assign addressed = (cmd.dev == pos_q) || (cmd.dev == dcae_pkg::BCAST_ADDR); // [R1]
	assign base_id = good && ident && !cmd.rw && cmd.dev == 4'h0 && cmd.stack == dcae_pkg::BASE_STACK; // [R7]
	assign done_id = good && ident && !cmd.rw && st_q == ST_ENUM && cmd.stack == dcae_pkg::DONE_STACK;
	// only the first device without a position takes the new address
	assign claim = good && ident && !cmd.rw && st_q == ST_ENUM && !done_id && cmd.stack != dcae_pkg::BASE_STACK
		&& pos_q == dcae_pkg::POS_NONE && prior_placed; // [R10]
	assign track = good && ident && !cmd.rw && st_q == ST_ENUM && !done_id && cmd.stack != dcae_pkg::BASE_STACK
		&& pos_q != dcae_pkg::POS_NONE; // [R12]
	// top enters at once, the rest after the ack has had time to pass down
	assign enter = (base_id && is_top) || (st_q == ST_RELAY && relay_q == 16'h0000); // [R8]

	// response selection
	always_comb
	begin
		reply = 1'b0;
		kind = dcae_pkg::K_ACK;
		if (good && ident)
		begin
			if (base_id)
			begin
				reply = is_top; // [R8]
			end
			else if (st_q != ST_ENUM)
			begin
				reply = addressed; // [R16]
				kind = dcae_pkg::K_NAK;
			end
			else if (done_id)
			begin
				reply = is_top; // [R15]
			end
			else if (claim)
			begin
				reply = 1'b1;
				kind = dcae_pkg::K_IDENT; // [R10]
			end
			else if (cmd.rw)
			begin
				reply = addressed;
				kind = dcae_pkg::K_NAK; // [R16]
			end
		end
		reply = reply && resp_en_q;
	end

	// response word; position field takes the new address in the same cycle
	always_comb
	begin
		body = '0;
		body.dev = claim ? cmd.stack[3:0] : pos_q;
		body.page = dcae_pkg::ID_PAGE;
		body.daddr = (kind == dcae_pkg::K_IDENT) ? dcae_pkg::ID_DADDR :
			(kind == dcae_pkg::K_ACK) ? dcae_pkg::ACK_DADDR : dcae_pkg::NAK_DADDR;
		if (kind == dcae_pkg::K_IDENT)
		begin
			body.addr = {role_select_bits, cmd.stack[3:0]}; // [R10] [R13]
		end
		body.zero = 8'h00; // [R11]
	end

	dcae_crc4 #(.W(32)) u_gen (
		.frame(body),
		.crc(resp_crc),
		.match()
	);

	// registered answer strobe
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			resp_valid <= 1'b0;
			resp_kind <= dcae_pkg::K_ACK;
			resp <= '0;
		end
		else
		begin
			resp_valid <= reply; // [R5]
			if (reply)
			begin
				resp_kind <= kind;
				resp <= {body[31:4], resp_crc}; // [R4]
			end
		end
	end

	// non-identify words go on to the rest of the device, tagged if they need a reply
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pass_valid <= 1'b0;
			pass_cmd <= '0;
		end
		else
		begin
			pass_valid <= good && !ident && addressed && !is_silent(cmd); // [R5] [R1]
			if (good && !ident)
			begin
				pass_cmd <= cmd;
			end
		end
	end

	// mode sequencing
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q <= ST_NORMAL;
			relay_q <= 16'h0000;
		end
		else
		begin
			case (st_q)
				ST_NORMAL, ST_ENUM:
				begin
					if (base_id && is_top)
					begin
						st_q <= ST_ENUM; // [R7]
					end
					else if (base_id)
					begin
						st_q <= ST_RELAY;
						relay_q <= relay_wait_q;
					end
					else if (done_id)
					begin
						st_q <= ST_NORMAL; // [R15]
					end
				end
				ST_RELAY:
				begin
					if (relay_q == 16'h0000)
					begin
						st_q <= ST_ENUM; // [R8]
					end
					else
					begin
						relay_q <= relay_q - 16'h0001;
					end
				end
				default:
				begin
					st_q <= ST_NORMAL;
				end
			endcase
		end
	end

	// stack position and chain length; untouched outside a sequence
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pos_q <= dcae_pkg::POS_NONE;
			size_q <= dcae_pkg::POS_NONE;
		end
		else if (enter)
		begin
			pos_q <= is_master ? dcae_pkg::POS_MASTER : dcae_pkg::POS_NONE; // [R9] [R19]
			size_q <= is_master ? dcae_pkg::POS_MASTER : dcae_pkg::POS_NONE;
		end
		else if (claim)
		begin
			pos_q <= cmd.stack[3:0]; // [R10] [R13]
			size_q <= cmd.stack[3:0];
		end
		else if (track)
		begin
			size_q <= cmd.stack[3:0]; // [R12]
		end
	end

	// checksum failure counter, saturating
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			crc_err_q <= 8'h00;
		end
		else if (cmd_valid && !crc_ok && crc_err_q != 8'hFF)
		begin
			crc_err_q <= crc_err_q + 8'h01; // [R17]
		end
	end

	// AXI4-Lite write: address and data taken together, one write at a time
	logic wr_go;
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= dcae_pkg::RESP_OKAY;
			relay_wait_q <= dcae_pkg::RELAY_WAIT_RST;
			resp_en_q <= dcae_pkg::CTRL_RESP_EN_RST;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= dcae_pkg::RESP_OKAY;
			if (s_axi_awaddr == dcae_pkg::CTRL_OFS)
			begin
				if (s_axi_wstrb[0])
				begin
					relay_wait_q[7:0] <= s_axi_wdata[dcae_pkg::CTRL_RELAY_LSB +: 8];
				end
				if (s_axi_wstrb[1])
				begin
					relay_wait_q[15:8] <= s_axi_wdata[dcae_pkg::CTRL_RELAY_LSB + 8 +: 8];
				end
				if (s_axi_wstrb[2])
				begin
					resp_en_q <= s_axi_wdata[dcae_pkg::CTRL_RESP_EN_BIT];
				end
			end
			else if (s_axi_awaddr != dcae_pkg::LINK_SETUP_OFS && s_axi_awaddr != dcae_pkg::STATE_OFS)
			begin
				s_axi_bresp <= dcae_pkg::RESP_SLVERR;
			end
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// AXI4-Lite read; read-only registers ignore writes but answer okay
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= dcae_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= dcae_pkg::RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			case (s_axi_araddr)
				dcae_pkg::LINK_SETUP_OFS:
				begin
					s_axi_rdata[dcae_pkg::ADDR_LSB +: 4] <= pos_q; // [R3]
					s_axi_rdata[dcae_pkg::SIZE_LSB +: 4] <= size_q;
					s_axi_rdata[dcae_pkg::ROLE_LSB +: 2] <= role_select_bits; // [R2]
					s_axi_rdata[dcae_pkg::RATE_LSB +: 2] <= link_rate_bits;
				end
				dcae_pkg::CTRL_OFS:
				begin
					s_axi_rdata[15:0] <= relay_wait_q;
					s_axi_rdata[dcae_pkg::CTRL_RESP_EN_BIT] <= resp_en_q;
				end
				dcae_pkg::STATE_OFS:
				begin
					s_axi_rdata[1:0] <= st_q;
					s_axi_rdata[15:8] <= crc_err_q;
				end
				default:
				begin
					s_axi_rresp <= dcae_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// checks
	a_crc_drop: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_valid && !crc_ok |=> !resp_valid && !pass_valid) else $error("bad checksum drew an answer"); // [R17]
	a_base_enter: assert property (@(posedge aclk) disable iff (!aresetn)
		base_id && is_top |=> st_q == ST_ENUM) else $error("top did not enter enumeration"); // [R7]
	a_top_ack: assert property (@(posedge aclk) disable iff (!aresetn)
		base_id && is_top && resp_en_q |=> resp_valid && resp_kind == dcae_pkg::K_ACK) else $error("top base ack missing"); // [R8]
	a_relay_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q == ST_RELAY && relay_q != 16'h0000 |=> st_q == ST_RELAY) else $error("entry before relay wait"); // [R8]
	a_entry_load: assert property (@(posedge aclk) disable iff (!aresetn)
		enter |=> pos_q == (is_master ? 4'h1 : 4'h0) && size_q == pos_q) else $error("wrong entry position"); // [R9]
	a_claim_pos: assert property (@(posedge aclk) disable iff (!aresetn)
		claim |=> pos_q == $past(cmd.stack[3:0]) && size_q == pos_q) else $error("address not taken"); // [R10]
	a_ident_word: assert property (@(posedge aclk) disable iff (!aresetn)
		resp_valid && resp_kind == dcae_pkg::K_IDENT |-> resp.addr == {role_select_bits, pos_q} && resp.zero == 8'h00)
		else $error("identify response malformed"); // [R11]
	a_size_track: assert property (@(posedge aclk) disable iff (!aresetn)
		track && !enter |=> size_q == $past(cmd.stack[3:0]) && $stable(pos_q)) else $error("size not tracked"); // [R12]
	a_done_exit: assert property (@(posedge aclk) disable iff (!aresetn)
		done_id |=> st_q == ST_NORMAL ##1 (st_q == ST_NORMAL || $past(base_id))) // [R15]
		else $error("enumeration not closed");
	a_normal_nak: assert property (@(posedge aclk) disable iff (!aresetn)
		good && ident && !base_id && st_q == ST_NORMAL && addressed && resp_en_q
		|=> resp_valid && resp_kind == dcae_pkg::K_NAK) else $error("normal mode identify not refused"); // [R16]
	a_pos_kept: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q == ST_NORMAL && !base_id |=> $stable(pos_q) && $stable(size_q)) else $error("position lost"); // [R19]
endmodule : dcae_enum

// File: inc/dcae_pkg.sv
// dcae_pkg: constants, field layouts and carrier types for the chain enumeration block
// assumes a 200 MHz single clock domain and AXI4-Lite register access
package dcae_pkg;

	// register byte offsets
	localparam logic [7:0] LINK_SETUP_OFS = 8'h18;
	localparam logic [7:0] CTRL_OFS = 8'h1C;
	localparam logic [7:0] STATE_OFS = 8'h20;

	// link setup field positions
	localparam int ADDR_LSB = 0;
	localparam int SIZE_LSB = 4;
	localparam int ROLE_LSB = 8;
	localparam int RATE_LSB = 10;

	// control register layout and reset value
	localparam int CTRL_RELAY_LSB = 0;
	localparam logic [15:0] RELAY_WAIT_RST = 16'h0040;
	localparam int CTRL_RESP_EN_BIT = 16;
	localparam logic CTRL_RESP_EN_RST = 1'b1;

	// role select pin codes
	localparam logic [1:0] ROLE_MASTER = 2'b01;
	localparam logic [1:0] ROLE_TOP = 2'b10;

	// command codes: identify lives at page 3, data address 6'h09
	localparam logic [2:0] ID_PAGE = 3'h3;
	localparam logic [5:0] ID_DADDR = 6'h09;
	localparam logic [5:0] BASE_STACK = 6'h00;
	localparam logic [5:0] DONE_STACK = 6'h3F;
	localparam logic [3:0] POS_MASTER = 4'h1;
	localparam logic [3:0] POS_NONE = 4'h0;
	localparam logic [3:0] BCAST_ADDR = 4'hF;

	// system page commands that never draw a reply
	localparam logic [2:0] SYS_PAGE = 3'h3;
	localparam logic [5:0] SCAN_DADDR_LO = 6'h01;
	localparam logic [5:0] SCAN_DADDR_HI = 6'h07;
	localparam logic [5:0] MEASURE_DADDR = 6'h08;
	localparam logic [5:0] RESET_DADDR = 6'h0C;

	// answer codes placed in the data address field of ack and nak words
	localparam logic [5:0] ACK_DADDR = 6'h0C;
	localparam logic [5:0] NAK_DADDR = 6'h0D;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {K_ACK, K_NAK, K_IDENT} dcae_kind_t;

	// 24-bit command word, sent msb first
	typedef struct packed {
		logic [3:0] dev;
		logic rw;
		logic [2:0] page;
		logic [5:0] daddr;
		logic [5:0] stack;
		logic [3:0] crc;
	} dcae_cmd_t;

	// 32-bit response word, sent msb first
	typedef struct packed {
		logic [3:0] dev;
		logic rw;
		logic [2:0] page;
		logic [5:0] daddr;
		logic [5:0] addr;
		logic [7:0] zero;
		logic [3:0] crc;
	} dcae_resp_t;

endpackage : dcae_pkg

// File: src/dcae_crc4.sv
// dcae_crc4: four-bit frame checksum over all bits but the last nibble
// assumes the frame is presented whole; purely combinational
`timescale 1ns/10ps
module dcae_crc4 #(
	parameter int W = 24
) (
	input wire logic [W-1:0] frame,
	output logic [3:0] crc,
	output logic match
);
	// shift in msb first, last nibble excluded
	always_comb
	begin
		crc = 4'h0;
		for (int i = W - 1; i >= 4; i--)
		begin
			crc = {crc[2], crc[1], crc[0] ^ crc[3], frame[i] ^ crc[3]}; // [R18] [R4]
		end
		match = (crc == frame[3:0]); // [R17]
	end
endmodule : dcae_crc4

// File: tb/dcae_host_model.sv
// dcae_host_model: host stand-in that frames command words with their checksum
// assumes the bench calls send and then watches the block's answer strobe itself
`timescale 1ns/10ps
module dcae_host_model (
	input wire logic aclk,
	output logic cmd_valid,
	output dcae_pkg::dcae_cmd_t cmd
);
	// quiet bus at time zero
	initial
	begin
		cmd_valid = 1'b0;
		cmd = '0;
	end

	// checksum over bits n-1 down to 4, msb first
	function automatic logic [3:0] crc4(input logic [31:0] f, input int n);
		logic [3:0] c;
		logic b;
		c = 4'h0;
		for (int i = n - 1; i >= 4; i--)
		begin
			b = f[i] ^ c[3];
			c = {c[2], c[1], c[0] ^ c[3], b};
		end
		return c;
	endfunction : crc4

	// one-cycle strobe; the word is scrambled after so a stale value never looks valid
	task automatic send(input logic [3:0] dev, input logic rw, input logic [5:0] da,
		input logic [5:0] stk, input logic bad);
		dcae_pkg::dcae_cmd_t c;
		c = {dev, rw, dcae_pkg::ID_PAGE, da, stk, 4'h0};
		c.crc = crc4({8'h00, c}, 24) ^ {3'b000, bad};
		@(posedge aclk);
		cmd_valid <= 1'b1;
		cmd <= c;
		@(posedge aclk);
		cmd_valid <= 1'b0;
		cmd <= ~c;
	endtask : send
endmodule : dcae_host_model

// File: tb/testbench.sv
// testbench: register and command sequences for the enumeration block
// assumes the block answers one cycle after a taken command word
`timescale 1ns/10ps
module testbench;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, prior, cmd_valid, resp_valid, pass_valid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, role, rate;
	dcae_pkg::dcae_cmd_t cmd, pass_cmd;
	dcae_pkg::dcae_kind_t resp_kind;
	dcae_pkg::dcae_resp_t resp;
	logic [5:0] quiet [4];
	int failures, n_compared;

	dcae_enum DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .role_select_bits(role),
		.link_rate_bits(rate), .prior_placed(prior), .cmd_valid(cmd_valid), .cmd(cmd),
		.resp_valid(resp_valid), .resp_kind(resp_kind), .resp(resp), .pass_valid(pass_valid),
		.pass_cmd(pass_cmd));
	dcae_host_model host (.aclk(aclk), .cmd_valid(cmd_valid), .cmd(cmd));

	// 200 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	// ready is looked at 1 ns past an edge, so it is the value the next edge samples
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		#1;
		while (!(awready && wready))
		begin
			@(posedge aclk);
			#1;
		end
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		#1;
		while (!bvalid)
		begin
			@(posedge aclk);
			#1;
		end
		chk(bresp, er, "bresp");
		@(posedge aclk);
		bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		#1;
		while (!arready)
		begin
			@(posedge aclk);
			#1;
		end
		@(posedge aclk);
		arvalid <= 1'b0;
		#1;
		while (!rvalid)
		begin
			@(posedge aclk);
			#1;
		end
		d = rdata;
		chk(rresp, er, "rresp");
		@(posedge aclk);
		rready <= 1'b0;
	endtask : axi_read

	// command word then the answer strobe in the cycle after the taking edge
	task automatic cmd_chk(input logic [3:0] dev, input logic rw, input logic [5:0] da, input logic [5:0] stk,
		input logic bad, input logic ev, input dcae_pkg::dcae_kind_t ek);
		host.send(dev, rw, da, stk, bad);
		#1;
		chk(resp_valid, ev, "resp_valid");
		if (ev)
			chk(resp_kind, ek, "resp_kind");
		if (ev)
			chk(resp.crc, host.crc4(resp, 32), "resp crc");
	endtask : cmd_chk

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		axi_read(a, rd, dcae_pkg::RESP_OKAY);
		chk(rd & mask, exp, "register");
	endtask : rd_chk

	// main sequence
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		role = 2'b11;
		rate = 2'b10;
		prior = 1'b1;
		quiet = '{dcae_pkg::SCAN_DADDR_LO, dcae_pkg::SCAN_DADDR_HI, dcae_pkg::MEASURE_DADDR,
			dcae_pkg::RESET_DADDR};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(dcae_pkg::LINK_SETUP_OFS, 32'hFFFFFFFF, 32'h00000B00);
		axi_read(8'h40, rd, dcae_pkg::RESP_SLVERR);
		chk(rd, 32'h0, "unmapped data");
		axi_write(8'h44, 32'h0, dcae_pkg::RESP_SLVERR);
		axi_write(dcae_pkg::CTRL_OFS, 32'h00010004, dcae_pkg::RESP_OKAY); // short relay wait
		$display("test registers done");
		cmd_chk(4'h0, 1'b0, dcae_pkg::ID_DADDR, 6'h00, 1'b0, 1'b0, dcae_pkg::K_ACK);
		repeat (4) @(posedge aclk);
		rd_chk(dcae_pkg::STATE_OFS, 32'h3, 32'h2);
		rd_chk(dcae_pkg::LINK_SETUP_OFS, 32'hFF, 32'h00);
		// an unplaced device nearer the master must take the address first
		prior <= 1'b0;
		cmd_chk(4'h0, 1'b0, dcae_pkg::ID_DADDR, 6'h02, 1'b0, 1'b0, dcae_pkg::K_ACK);
		prior <= 1'b1;
		cmd_chk(4'h0, 1'b0, dcae_pkg::ID_DADDR, 6'h02, 1'b0, 1'b1, dcae_pkg::K_IDENT);
		chk(resp.addr, 6'h32, "ident addr");
		chk(resp.zero, 8'h00, "ident low bits");
		chk(resp.dev, 4'h2, "ident dev");
		cmd_chk(4'h0, 1'b0, dcae_pkg::ID_DADDR, 6'h03, 1'b0, 1'b0, dcae_pkg::K_ACK);
		rd_chk(dcae_pkg::LINK_SETUP_OFS, 32'hFF, 32'h32);
		cmd_chk(4'h0, 1'b0, dcae_pkg::ID_DADDR, 6'h3F, 1'b0, 1'b0, dcae_pkg::K_ACK);
		rd_chk(dcae_pkg::STATE_OFS, 32'h3, 32'h0);
		rd_chk(dcae_pkg::LINK_SETUP_OFS, 32'hFF, 32'h32);
		$display("test mid device enumeration done");
		cmd_chk(4'h2, 1'b0, dcae_pkg::ID_DADDR, 6'h02, 1'b0, 1'b1, dcae_pkg::K_NAK);
		cmd_chk(4'hF, 1'b1, dcae_pkg::ID_DADDR, 6'h00, 1'b0, 1'b1, dcae_pkg::K_NAK);
		cmd_chk(4'h5, 1'b0, dcae_pkg::ID_DADDR, 6'h02, 1'b0, 1'b0, dcae_pkg::K_ACK);
		// answers switched off: the refusal is suppressed, then answers come back on
		axi_write(dcae_pkg::CTRL_OFS, 32'h00000004, dcae_pkg::RESP_OKAY);
		cmd_chk(4'h2, 1'b0, dcae_pkg::ID_DADDR, 6'h02, 1'b0, 1'b0, dcae_pkg::K_ACK);
		rd_chk(dcae_pkg::CTRL_OFS, 32'h0001FFFF, 32'h00000004);
		axi_write(dcae_pkg::CTRL_OFS, 32'h00010004, dcae_pkg::RESP_OKAY);
		cmd_chk(4'h0, 1'b0, dcae_pkg::ID_DADDR, 6'h00, 1'b1, 1'b0, dcae_pkg::K_ACK);
		repeat (6) @(posedge aclk);
		rd_chk(dcae_pkg::STATE_OFS, 32'hFF03, 32'h0100);
		host.send(4'h2, 1'b0, 6'h0A, 6'h00, 1'b0);
		#1;
		chk(pass_valid, 1'b1, "pass");
		chk(pass_cmd[23:4], {4'h2, 1'b0, dcae_pkg::ID_PAGE, 6'h0A, 6'h00}, "pass word");
		foreach (quiet[i])
		begin
			host.send(4'h2, 1'b0, quiet[i], 6'h00, 1'b0);
			#1;
			chk(pass_valid | resp_valid, 1'b0, "quiet");
		end
		$display("test normal mode done");
		@(posedge aclk);
		role <= 2'b10;
		cmd_chk(4'h0, 1'b0, dcae_pkg::ID_DADDR, 6'h00, 1'b0, 1'b1, dcae_pkg::K_ACK);
		chk(resp.daddr, dcae_pkg::ACK_DADDR, "ack code");
		rd_chk(dcae_pkg::STATE_OFS, 32'h3, 32'h2);
		cmd_chk(4'h0, 1'b0, dcae_pkg::ID_DADDR, 6'h02, 1'b0, 1'b1, dcae_pkg::K_IDENT);
		chk(resp.addr, 6'h22, "top addr");
		cmd_chk(4'h0, 1'b0, dcae_pkg::ID_DADDR, 6'h3F, 1'b0, 1'b1, dcae_pkg::K_ACK);
		$display("test top device done");
		@(posedge aclk);
		role <= 2'b01;
		cmd_chk(4'h0, 1'b0, dcae_pkg::ID_DADDR, 6'h00, 1'b0, 1'b0, dcae_pkg::K_ACK);
		repeat (6) @(posedge aclk);
		rd_chk(dcae_pkg::LINK_SETUP_OFS, 32'hFFF, 32'h911);
		$display("test master device done");
		print_verdict();
	end

	// watchdog, far beyond the hundred or so cycles the tests need
	initial
	begin
		#100000;
		failures++;
		$display("[FAIL] %0t watchdog expired", $time);
		print_verdict();
	end
endmodule : testbench
